// File: rtl/pll_div_pkg.sv
`default_nettype none

package pll_div_pkg;

  localparam int          NUM_DIV    = 5;
  localparam int          CNT_W      = 8;
  localparam int          ADR_W      = 8;
  // register map, byte addresses
  localparam logic [7:0]  CFG_BASE   = 8'h00;
  localparam logic [7:0]  PHASE_BASE = 8'h20;
  localparam logic [7:0]  STATUS_OFS = 8'h40;
  localparam logic [7:0]  REG_STRIDE = 8'h04;
  // divider register fields
  localparam int          HIGH_LSB   = 0;
  localparam int          LOW_LSB    = 8;
  localparam int          BYPASS_BIT = 16;
  localparam int          ODD_BIT    = 17;
  // reset values: divide by two, no phase offset
  localparam logic [17:0] CFG_RESET  = 18'h00101;
  localparam logic [7:0]  PHASE_RESET = 8'h00;

  typedef struct packed {
    logic             odd;
    logic             bypass;
    logic [CNT_W-1:0] low;
    logic [CNT_W-1:0] high;
  } div_cfg_s;

  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [3:0]       sel;
    logic [ADR_W-1:0] adr;
    logic [31:0]      dat;
  } wb_req_s;

  typedef struct packed {
    div_cfg_s [NUM_DIV-1:0]              cfg;
    logic     [NUM_DIV-1:0][CNT_W-1:0]   phase;
    logic     [NUM_DIV-1:0][CNT_W:0]     cnt;
    logic     [NUM_DIV-1:0][CNT_W-1:0]   hold;
    logic     [NUM_DIV-1:0]              lvl;
    logic     [NUM_DIV-1:0]              tgl;
    logic                                ack;
    logic     [31:0]                     rdat;
  } state_s;

endpackage : pll_div_pkg

`default_nettype wire

// File: rtl/pll_post_scale_divider.sv
// Operation
// - five dividers, retuned live over the bus
// - eight-bit high and low counts per divider
// - duty is high over high-plus-low period
// - bypass bit one passes clock, divide one
// - bypass zero divides by high plus low
// - odd clear: output falls on rising edge
// - odd set: output falls on falling edge
// - odd set: high minus half, low plus half
// - divider writes never touch phase setting
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module pll_post_scale_divider (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire pll_div_pkg::wb_req_s        wb_req_i,
  output logic [31:0]                      wb_dat_o,
  output logic                             wb_ack_o,
  output logic [pll_div_pkg::NUM_DIV-1:0]  div_clk_o
);

  pll_div_pkg::state_s                       s;
  pll_div_pkg::state_s                       next_s;
  logic [pll_div_pkg::NUM_DIV-1:0]           lvl_fall;
  logic [pll_div_pkg::NUM_DIV-1:0]           tgl_fall;
  logic                                      hit;
  logic [31:0]                               wmask;
  logic [pll_div_pkg::NUM_DIV-1:0][8:0]      total;
  logic [pll_div_pkg::NUM_DIV-1:0][8:0]      hadj;

  function automatic logic [8:0] eff(input logic [7:0] v);
    eff = (v == 8'h00) ? 9'h001 : {1'b0, v};
  endfunction : eff

  assign hit   = wb_req_i.cyc & wb_req_i.stb & ~s.ack;
  assign wmask = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
                  {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};

  always_comb begin
    logic [31:0] old_w;
    logic [31:0] new_w;
    logic [8:0]  next_hadj;
    old_w  = 32'h0000_0000;
    new_w  = 32'h0000_0000;
    next_hadj = 9'h000;
    next_s = s;
    next_s.ack  = hit;
    next_s.rdat = 32'h0000_0000;
    for (int i = 0; i < pll_div_pkg::NUM_DIV; i++) begin
      total[i] = eff(s.cfg[i].high) + eff(s.cfg[i].low);
      hadj[i]  = s.cfg[i].odd ? eff(s.cfg[i].high) - 9'h001
                              : eff(s.cfg[i].high);
      // free running period count, held off while a phase delay runs
      if (s.hold[i] != 8'h00) begin
        next_s.hold[i] = s.hold[i] - 8'h01;
      end else if (s.cnt[i] + 9'h001 >= total[i]) begin
        next_s.cnt[i] = 9'h000;
      end else begin
        next_s.cnt[i] = s.cnt[i] + 9'h001;
      end
      next_s.tgl[i] = s.cfg[i].bypass ? ~s.tgl[i] : 1'b0;
      // divider write restarts the period and leaves phase alone
      if (hit && wb_req_i.we && wb_req_i.adr == pll_div_pkg::CFG_BASE
          + 8'(i) * pll_div_pkg::REG_STRIDE) begin
        old_w = {14'h0000, s.cfg[i]};
        new_w = (old_w & ~wmask) | (wb_req_i.dat & wmask);
        next_s.cfg[i]  = new_w[17:0];
        next_s.cnt[i]  = 9'h000;
        next_s.hold[i] = 8'h00;
      end
      // phase write delays the period start by that many cycles
      if (hit && wb_req_i.we && wb_req_i.adr == pll_div_pkg::PHASE_BASE
          + 8'(i) * pll_div_pkg::REG_STRIDE && wb_req_i.sel[0]) begin
        next_s.phase[i] = wb_req_i.dat[7:0];
        next_s.cnt[i]   = 9'h000;
        next_s.hold[i]  = wb_req_i.dat[7:0];
      end
      // level must follow the setting that is live next cycle
      next_hadj = next_s.cfg[i].odd ? eff(next_s.cfg[i].high) - 9'h001
                                    : eff(next_s.cfg[i].high);
      next_s.lvl[i] = (next_s.hold[i] == 8'h00)
                      && (next_s.cnt[i] < next_hadj);
      if (hit && !wb_req_i.we) begin
        if (wb_req_i.adr == pll_div_pkg::CFG_BASE
            + 8'(i) * pll_div_pkg::REG_STRIDE) begin
          next_s.rdat = {14'h0000, s.cfg[i]};
        end
        if (wb_req_i.adr == pll_div_pkg::PHASE_BASE
            + 8'(i) * pll_div_pkg::REG_STRIDE) begin
          next_s.rdat = {24'h000000, s.phase[i]};
        end
      end
    end
    if (hit && !wb_req_i.we && wb_req_i.adr == pll_div_pkg::STATUS_OFS) begin
      next_s.rdat = {{(32 - pll_div_pkg::NUM_DIV){1'b0}}, s.lvl};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s      <= '0;
      s.cfg  <= {pll_div_pkg::NUM_DIV{pll_div_pkg::CFG_RESET}};
      s.phase <= {pll_div_pkg::NUM_DIV{pll_div_pkg::PHASE_RESET}};
    end else begin
      s <= next_s;
    end
  end

  // half-cycle retiming for odd mode and bypass
  always_ff @(negedge clk_i) begin
    if (rst_i) begin
      lvl_fall <= '0;
      tgl_fall <= '0;
    end else begin
      lvl_fall <= s.lvl;
      tgl_fall <= s.tgl;
    end
  end

  always_comb begin
    for (int i = 0; i < pll_div_pkg::NUM_DIV; i++) begin
      if (s.cfg[i].bypass) begin
        div_clk_o[i] = s.tgl[i] ^ tgl_fall[i];
      end else if (s.cfg[i].odd) begin
        div_clk_o[i] = s.lvl[i] | lvl_fall[i];
      end else begin
        div_clk_o[i] = s.lvl[i];
      end
    end
  end

  assign wb_dat_o = s.rdat;
  assign wb_ack_o = s.ack;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence seq_bus_req;
    wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
  endsequence

  sequence seq_status_read;
    seq_bus_req ##0 (!wb_req_i.we
                     && wb_req_i.adr == pll_div_pkg::STATUS_OFS);
  endsequence

  chk_ack_one_cycle: assert property (seq_bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after request");

  chk_status_read: assert property (
    seq_status_read |=> wb_dat_o
      == {{(32 - pll_div_pkg::NUM_DIV){1'b0}}, $past(s.lvl)})
    else $error("status read does not show output levels");

  // per-divider checks, one copy for each divider
  for (genvar g = 0; g < pll_div_pkg::NUM_DIV; g++) begin : gen_chk

    sequence seq_cfg_write;
      seq_bus_req ##0 (wb_req_i.we && wb_req_i.sel == 4'hF
                       && wb_req_i.adr == pll_div_pkg::CFG_BASE
                          + 8'(g) * pll_div_pkg::REG_STRIDE);
    endsequence

    sequence seq_cfg_read;
      seq_bus_req ##0 (!wb_req_i.we
                       && wb_req_i.adr == pll_div_pkg::CFG_BASE
                          + 8'(g) * pll_div_pkg::REG_STRIDE);
    endsequence

    chk_cfg_write_takes: assert property (
      seq_cfg_write |=> s.cfg[g] == $past(wb_req_i.dat[17:0]))
      else $error("divider write not stored");

    chk_cfg_read_back: assert property (
      seq_cfg_read |=> wb_dat_o == {14'h0000, $past(s.cfg[g])})
      else $error("divider read does not return its setting");

    chk_phase_kept: assert property (
      seq_cfg_write |=> s.phase[g] == $past(s.phase[g]))
      else $error("divider write changed phase");

    chk_period_wraps: assert property (
      (s.hold[g] == 8'h00 && s.cnt[g] + 9'h001 == total[g] && !hit)
      |=> s.cnt[g] == 9'h000)
      else $error("period count did not wrap at high plus low");

    chk_count_bound: assert property (
      s.cnt[g] < total[g])
      else $error("period count beyond high plus low");

    chk_high_level: assert property (
      (!hit && s.hold[g] == 8'h00 && !s.cfg[g].odd && s.cnt[g] == 9'h000
       && s.cfg[g].high == 8'h02 && s.cfg[g].low == 8'h02)
      ##1 (!hit) [*3]
      |=> (s.lvl[g] && !$past(s.lvl[g]) && !$past(s.lvl[g], 2)
           && $past(s.lvl[g], 3)))
      else $error("two-two divider not high two then low two");

    chk_odd_short: assert property (
      (s.cfg[g].odd && !hit && s.hold[g] == 8'h00
       && s.cnt[g] + 9'h002 == eff(s.cfg[g].high)
       && s.cnt[g] + 9'h002 < total[g])
      |=> !s.lvl[g])
      else $error("odd mode high time not shortened");

    chk_low_phase: assert property (
      (s.cnt[g] >= hadj[g]) |-> !s.lvl[g])
      else $error("output high during low count");

    chk_hold_quiet: assert property (
      (s.hold[g] != 8'h00) |-> (!s.lvl[g] && s.cnt[g] == 9'h000))
      else $error("output moved during phase delay");

    chk_half_follow: assert property (
      lvl_fall[g] == s.lvl[g])
      else $error("falling-edge copy lags the output level");

    chk_bypass_toggle: assert property (
      (s.cfg[g].bypass && $past(s.cfg[g].bypass))
      |-> s.tgl[g] != $past(s.tgl[g]))
      else $error("bypass toggle stalled");

  end

endmodule : pll_post_scale_divider

`default_nettype wire

// File: sim/wb_user_model.sv
`timescale 1ns/1ps
`default_nettype none

module wb_user_model (
  input  wire logic                clk_i,
  input  wire logic                wb_ack_i,
  input  wire logic [31:0]         wb_dat_i,
  output var pll_div_pkg::wb_req_s wb_req_o
);
  initial wb_req_o = '0;

  // one classic cycle; waits for ack, then releases
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_req_o <= '{1'b1, 1'b1, w, 4'hF, a, d};
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    q = wb_dat_i;
    wb_req_o <= '0;
  endtask : xfer
endmodule : wb_user_model
`default_nettype wire

// File: sim/tb_pll_post_scale_divider.sv
`timescale 1ns/1ps
`default_nettype none

module tb_pll_post_scale_divider;
  logic                 clk_i = 1'b0;
  logic                 rst_i = 1'b1;
  logic [31:0]          wb_dat_o;
  logic                 wb_ack_o;
  logic [4:0]           div_clk_o;
  pll_div_pkg::wb_req_s wb_req;
  int                   bad_count = 0;
  int                   num_checks = 0;
  logic [31:0]          q, hi, per;
  logic [31:0]          cfg_t [5] = '{32'h00000202, 32'h00010101,
                                      32'h00020102, 32'h00000505,
                                      32'h00000604};
  logic [31:0]          hi_t  [5] = '{32'h14, 32'h5, 32'hF, 32'h32, 32'h28};
  logic [31:0]          per_t [5] = '{32'h28, 32'hA, 32'h1E, 32'h64,
                                      32'h64};

  always #5 clk_i = ~clk_i;

  pll_post_scale_divider DUT (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .wb_req_i  (wb_req),
    .wb_dat_o  (wb_dat_o),
    .wb_ack_o  (wb_ack_o),
    .div_clk_o (div_clk_o)
  );

  wb_user_model usr (
    .clk_i    (clk_i),
    .wb_ack_i (wb_ack_o),
    .wb_dat_i (wb_dat_o),
    .wb_req_o (wb_req)
  );

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h exp %h", $time, s, e);
    end
  endtask : chk

  task automatic report_and_stop;
    if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // high time and period in ns, from one rising edge to the next
  task automatic meas(input int i, output logic [31:0] h,
                      output logic [31:0] p);
    realtime t0, t1, t2;
    @(posedge div_clk_o[i]);
    t0 = $realtime;
    @(negedge div_clk_o[i]);
    t1 = $realtime;
    @(posedge div_clk_o[i]);
    t2 = $realtime;
    h = 32'(int'(t1 - t0));
    p = 32'(int'(t2 - t0));
  endtask : meas

  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    usr.xfer(1'b0, pll_div_pkg::CFG_BASE, 32'h0, q);
    chk(q, 32'(pll_div_pkg::CFG_RESET));
    usr.xfer(1'b0, 8'h80, 32'h0, q);
    chk(q, 32'h0);
    usr.xfer(1'b1, pll_div_pkg::PHASE_BASE + 8'h0C, 32'h3, q);
    for (int i = 0; i < 5; i++) begin
      usr.xfer(1'b1, pll_div_pkg::CFG_BASE + 8'(4 * i), cfg_t[i], q);
      usr.xfer(1'b0, pll_div_pkg::CFG_BASE + 8'(4 * i), 32'h0, q);
      chk(q, cfg_t[i]);
      meas(i, hi, per);
      chk(hi, hi_t[i]);
      chk(per, per_t[i]);
    end
    usr.xfer(1'b0, pll_div_pkg::PHASE_BASE + 8'h0C, 32'h0, q);
    chk(q, 32'h3);
    usr.xfer(1'b1, pll_div_pkg::PHASE_BASE + 8'h0C, 32'h3, q);
    meas(3, hi, per);
    chk(per, 32'h64);
    // restart all dividers with long high times; all outputs then high
    for (int i = 0; i < 5; i++) begin
      usr.xfer(1'b1, pll_div_pkg::CFG_BASE + 8'(4 * i), 32'h0000FFFF, q);
    end
    usr.xfer(1'b0, pll_div_pkg::STATUS_OFS, 32'h0, q);
    chk(q, 32'h0000001F);
    report_and_stop();
  end
endmodule : tb_pll_post_scale_divider
`default_nettype wire
